// >>> rtl/iee_consts.svh
// Constants of the two-wire EEPROM slave
`ifndef IEE_CONSTS_SVH
`define IEE_CONSTS_SVH
`define IEE_MEM_BYTES 8192
`define IEE_AW 13
`define IEE_PAGE_BYTES 32
`define IEE_OFF_W 5
`define IEE_PAGE_W 8
`define IEE_BYTE_BITS 4'h8
`define IEE_PH_AHI 2'h0
`define IEE_PH_ALO 2'h1
`define IEE_PH_DATA 2'h2
`define IEE_ERASED 8'hFF
`define IEE_SEL_LOW 3'h0
`define IEE_SEL_HIGH 3'h4
`define IEE_CORE_MHZ 100
`define IEE_PROG_TIME_MS 5
`define IEE_PROG_CYC (`IEE_PROG_TIME_MS * `IEE_CORE_MHZ * 1000)
`define IEE_CNT_W 20
`endif

// >>> rtl/iee_pkg.sv
// Types of the two-wire EEPROM slave
package iee_pkg;
`include "iee_consts.svh"

typedef logic [2:0] iee_sel_t;

typedef enum logic [2:0] {
	ST_IDLE = 3'h0,
	ST_DEVADR = 3'h1,
	ST_DEVACK = 3'h2,
	ST_RXBYTE = 3'h3,
	ST_RXACK = 3'h4,
	ST_TXBYTE = 3'h5,
	ST_TXACK = 3'h6
} iee_state_t;

typedef struct packed {
	logic scl_s1;
	logic scl_s2;
	logic scl_p;
	logic sda_s1;
	logic sda_s2;
	logic sda_p;
	iee_sel_t sel_s1;
	iee_sel_t sel_s2;
	logic wp_s1;
	logic wp_s2;
	logic en_s1;
	logic en_s2;
	logic busy_s1;
	logic busy_s2;
	iee_state_t st;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic [1:0] ph;
	logic rw;
	logic mack;
	logic wp_lat;
	logic pend;
	logic prog_wait;
	logic launch_tgl;
	logic sda_o;
	logic sda_oe_n;
	logic [`IEE_AW-1:0] addr;
	logic [`IEE_PAGE_W-1:0] page;
	logic [`IEE_OFF_W-1:0] off;
	logic [`IEE_PAGE_BYTES-1:0] valid;
	logic [`IEE_PAGE_BYTES-1:0][7:0] pbuf;
	logic [`IEE_MEM_BYTES-1:0][7:0] mem;
} iee_link_t;

typedef struct packed {
	logic tg_s1;
	logic tg_s2;
	logic tg_p;
	logic busy;
	logic [`IEE_CNT_W-1:0] cnt;
} iee_core_t;
endpackage

// >>> rtl/iee_slave.sv
// Two-wire serial EEPROM slave with page buffer and program timer
//
// Operation
// - Silent until a START is seen
// - Detect START and STOP while clock high
// - STOP returns protocol engine to idle
// - Driven data stable while clock high
// - Pinless variant matches fixed select 000/100
// - Address LSB picks read or write
// - Release data on ninth clock; receiver acks
// - Byte write: address, two offsets, data, STOP
// - Program after STOP; no ack while busy
// - Up to 32 bytes into page buffer
// - Page latched, offset increments and wraps
// - Commit all written page bytes in one cycle
// - Write protect high blocks all writes
// - Protect sampled before first data byte
// - Array starts erased to FFh
// - Immediate read sends current address byte
// - Selective read loads address first
// - Sequential read increments, wraps whole array
// - Send zero by pulling low only
// - Sample on rising, change after falling
// - Floating select pins read low
// - Floating protect pin reads low
`timescale 1ns/1ps
module iee_slave #(
	parameter int unsigned PROG_CYCLES = `IEE_PROG_CYC,
	parameter logic [3:0] DEV_TYPE = 4'h5, // Arbitrary type code
	parameter bit HAS_SEL_PINS = 1'h1,
	parameter bit SEL_HIGH = 1'h0
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic core_en,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire iee_pkg::iee_sel_t chip_select_pins,
	input wire logic write_protect_input,
	output logic write_busy
);
	import iee_pkg::*;

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	iee_link_t q;
	iee_link_t d;
	iee_core_t c_q;
	iee_core_t c_d;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_end;
	logic link_busy;
	logic dev_match;
	iee_sel_t sel_exp;

	// Sampled lines only; a bus glitch shorter than one link clock can be missed
	assign scl_rise = q.scl_s2 & ~q.scl_p;
	assign scl_fall = ~q.scl_s2 & q.scl_p;
	assign start_det = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
	assign stop_det = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
	assign byte_end = scl_fall & (q.cnt == `IEE_BYTE_BITS);
	// Busy seen locally at once; the core flag arrives two edges late
	assign link_busy = q.prog_wait | q.busy_s2;
	// Pads pull floating selects low, so the sampled level is used as is
	assign sel_exp = HAS_SEL_PINS ? q.sel_s2 : (SEL_HIGH ? `IEE_SEL_HIGH : `IEE_SEL_LOW);
	assign dev_match = (q.sh[7:4] == DEV_TYPE) && (q.sh[3:1] == sel_exp);

	always_comb begin
		d = q;
		d.scl_s1 = scl_i;
		d.scl_s2 = q.scl_s1;
		d.sda_s1 = sda_i;
		d.sda_s2 = q.sda_s1;
		d.sel_s1 = chip_select_pins;
		d.sel_s2 = q.sel_s1;
		d.wp_s1 = write_protect_input;
		d.wp_s2 = q.wp_s1;
		d.en_s1 = core_en;
		d.en_s2 = q.en_s1;
		d.busy_s1 = c_q.busy;
		d.busy_s2 = q.busy_s1;
		d.sda_o = 1'h0;
		if (q.en_s2) begin
			d.scl_p = q.scl_s2;
			d.sda_p = q.sda_s2;
			if (q.prog_wait && q.busy_s2) begin
				d.prog_wait = 1'h0;
			end
			if (stop_det) begin
				d.st = ST_IDLE;
				d.sda_oe_n = 1'h1;
				if (q.pend) begin
					// Every buffered byte marked valid lands at once, before the timer runs
					for (int i = 0; i < `IEE_PAGE_BYTES; i++) begin
						if (q.valid[i]) begin
							d.mem[{q.page, `IEE_OFF_W'(i)}] = q.pbuf[i];
						end
					end
					d.launch_tgl = ~q.launch_tgl;
					d.prog_wait = 1'h1;
				end
				d.pend = 1'h0;
				d.valid = '0;
			end else if (start_det) begin
				d.st = ST_DEVADR;
				d.cnt = 4'h0;
				d.sda_oe_n = 1'h1;
				d.pend = 1'h0;
				d.valid = '0;
			end else begin
				unique case (q.st)
					ST_IDLE: begin
					end
					ST_DEVADR: begin
						if (scl_rise) begin
							d.sh = {q.sh[6:0], q.sda_s2};
							d.cnt = q.cnt + 4'h1;
						end
						if (byte_end) begin
							if (dev_match && !link_busy) begin
								d.st = ST_DEVACK;
								d.sda_oe_n = 1'h0;
								d.rw = q.sh[0];
							end else begin
								d.st = ST_IDLE;
							end
						end
					end
					ST_DEVACK: begin
						if (scl_fall) begin
							d.cnt = 4'h0;
							if (q.rw) begin
								d.sh = q.mem[q.addr];
								d.sda_oe_n = q.mem[q.addr][7];
								d.addr = q.addr + 1'h1;
								d.st = ST_TXBYTE;
							end else begin
								d.sda_oe_n = 1'h1;
								d.st = ST_RXBYTE;
								d.ph = `IEE_PH_AHI;
							end
						end
					end
					ST_RXBYTE: begin
						if (scl_rise) begin
							d.sh = {q.sh[6:0], q.sda_s2};
							d.cnt = q.cnt + 4'h1;
						end
						if (byte_end) begin
							d.st = ST_RXACK;
							d.sda_oe_n = 1'h0;
							unique case (q.ph)
								`IEE_PH_AHI: begin
									d.addr[`IEE_AW-1:8] = q.sh[`IEE_AW-9:0];
								end
								`IEE_PH_ALO: begin
									d.addr[7:0] = q.sh;
									d.page = {q.addr[`IEE_AW-1:8], q.sh[7:5]};
									d.off = q.sh[4:0];
								end
								`IEE_PH_DATA: begin
									if (q.wp_lat) begin
										d.st = ST_IDLE;
										d.sda_oe_n = 1'h1;
									end else begin
										d.pbuf[q.off] = q.sh;
										d.valid[q.off] = 1'h1;
										d.off = q.off + 5'h01;
										d.addr = {q.page, q.off + 5'h01};
										d.pend = 1'h1;
									end
								end
								default: begin
									d.st = ST_IDLE;
									d.sda_oe_n = 1'h1;
								end
							endcase
						end
					end
					ST_RXACK: begin
						if (scl_fall) begin
							d.sda_oe_n = 1'h1;
							d.st = ST_RXBYTE;
							d.cnt = 4'h0;
							if (q.ph == `IEE_PH_ALO) begin
								// Floating protect pin pulls low at the pad
								d.wp_lat = q.wp_s2;
							end
							if (q.ph != `IEE_PH_DATA) begin
								d.ph = q.ph + 2'h1;
							end
						end
					end
					ST_TXBYTE: begin
						if (scl_rise) begin
							d.sh = {q.sh[6:0], 1'h0};
							d.cnt = q.cnt + 4'h1;
						end
						if (scl_fall) begin
							if (q.cnt == `IEE_BYTE_BITS) begin
								d.sda_oe_n = 1'h1;
								d.st = ST_TXACK;
							end else begin
								d.sda_oe_n = q.sh[7];
							end
						end
					end
					ST_TXACK: begin
						if (scl_rise) begin
							d.mack = ~q.sda_s2;
						end
						if (scl_fall) begin
							if (q.mack) begin
								d.sh = q.mem[q.addr];
								d.sda_oe_n = q.mem[q.addr][7];
								d.addr = q.addr + 1'h1;
								d.cnt = 4'h0;
								d.st = ST_TXBYTE;
							end else begin
								d.st = ST_IDLE;
							end
						end
					end
					default: begin
						d.st = ST_IDLE;
						d.sda_oe_n = 1'h1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.mem <= {`IEE_MEM_BYTES{`IEE_ERASED}};
			// Lines assumed released, so no false START at release
			q.scl_s1 <= 1'h1;
			q.scl_s2 <= 1'h1;
			q.scl_p <= 1'h1;
			q.sda_s1 <= 1'h1;
			q.sda_s2 <= 1'h1;
			q.sda_p <= 1'h1;
			q.sda_oe_n <= 1'h1;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Core domain: program timer
	// ----------------------------------------
	always_comb begin
		c_d = c_q;
		c_d.tg_s1 = q.launch_tgl;
		c_d.tg_s2 = c_q.tg_s1;
		if (core_en) begin
			c_d.tg_p = c_q.tg_s2;
			if (c_q.tg_s2 != c_q.tg_p) begin
				c_d.busy = 1'h1;
				c_d.cnt = `IEE_CNT_W'(PROG_CYCLES - 1);
			end else if (c_q.busy) begin
				if (c_q.cnt == '0) begin
					c_d.busy = 1'h0;
				end else begin
					c_d.cnt = c_q.cnt - 1'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	assign sda_o = q.sda_o;
	assign sda_oe_n = q.sda_oe_n;
	assign write_busy = c_q.busy;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_quiet;
		q.en_s2 && !start_det && !stop_det;
	endsequence

	sequence s_dev_end;
		q.en_s2 && q.st == ST_DEVADR && byte_end;
	endsequence

	sequence s_data_end;
		q.en_s2 && q.st == ST_RXBYTE && q.ph == `IEE_PH_DATA && byte_end;
	endsequence

	sequence s_tx_ack_end;
		q.en_s2 && q.st == ST_TXACK && scl_fall;
	endsequence

	property p_silent_idle;
		@(posedge link_clk) disable iff (!nrst)
		s_quiet ##0 (q.st == ST_IDLE) |=> q.st == ST_IDLE && q.sda_oe_n;
	endproperty
	a_silent_idle: assert property (p_silent_idle) else $error("idle slave left idle or drove data");

	property p_start;
		@(posedge link_clk) disable iff (!nrst)
		q.en_s2 && start_det |=> q.st == ST_DEVADR && q.cnt == 4'h0 && q.sda_oe_n;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		@(posedge link_clk) disable iff (!nrst)
		q.en_s2 && stop_det |=> q.st == ST_IDLE && q.sda_oe_n && !q.pend;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not return to idle");

	property p_stable;
		@(posedge link_clk) disable iff (!nrst)
		q.scl_s2 && q.scl_p && !stop_det |=> $stable(q.sda_oe_n);
	endproperty
	a_stable: assert property (p_stable) else $error("data changed while clock high");

	property p_dev_ack;
		@(posedge link_clk) disable iff (!nrst)
		s_dev_end ##0 (dev_match && !link_busy) |=> q.st == ST_DEVACK && !q.sda_oe_n && q.rw == $past(q.sh[0]);
	endproperty
	a_dev_ack: assert property (p_dev_ack) else $error("matching address not acked");

	property p_dev_nack;
		@(posedge link_clk) disable iff (!nrst)
		s_dev_end ##0 (!dev_match || link_busy) |=> q.st == ST_IDLE && q.sda_oe_n;
	endproperty
	a_dev_nack: assert property (p_dev_nack) else $error("address acked while busy or foreign");

	property p_ack_release;
		@(posedge link_clk) disable iff (!nrst)
		s_quiet ##0 (q.st == ST_RXACK && scl_fall) |=> q.sda_oe_n && q.st == ST_RXBYTE && q.cnt == 4'h0;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack not released on ninth fall");

	property p_wp_nack;
		@(posedge link_clk) disable iff (!nrst)
		s_data_end ##0 q.wp_lat |=> q.sda_oe_n && q.st == ST_IDLE && $stable(q.valid) && !q.pend;
	endproperty
	a_wp_nack: assert property (p_wp_nack) else $error("protected write accepted");

	property p_page_wrap;
		@(posedge link_clk) disable iff (!nrst)
		s_data_end ##0 !q.wp_lat |=> q.off == $past(q.off) + 5'h01 && $stable(q.page) && q.pend;
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page offset did not advance");

	property p_read_inc;
		@(posedge link_clk) disable iff (!nrst)
		s_tx_ack_end ##0 q.mack |=> q.addr == $past(q.addr) + 1'h1 && q.st == ST_TXBYTE;
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read address did not advance");

	property p_launch;
		@(posedge link_clk) disable iff (!nrst)
		q.en_s2 && stop_det && q.pend |=> q.launch_tgl != $past(q.launch_tgl) ##1 link_busy;
	endproperty
	a_launch: assert property (p_launch) else $error("program cycle not launched");

	property p_busy_set;
		@(posedge core_clk) disable iff (!nrst)
		core_en && c_q.tg_s2 != c_q.tg_p |=> c_q.busy ##1 c_q.busy;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("program timer not started");
endmodule

// >>> tb/iee_bus_master.sv
// Bus master model for the two-wire slave
`timescale 1ns/1ps
module iee_bus_master (
	output logic scl,
	output logic sda_rel,
	input wire logic sda
);
	// Quarter bit: well above the slave's four link-clock minimum
	localparam int Q = 100;
	initial begin
		scl = 1'h1;
		sda_rel = 1'h1;
	end
	// Data moves only while the clock is low
	task automatic bit_cyc(input logic b, output logic r);
		scl = 1'h0;
		#Q sda_rel = b;
		#Q scl = 1'h1;
		r = sda;
		#(2*Q);
	endtask
	task automatic start();
		scl = 1'h0;
		#Q sda_rel = 1'h1;
		#Q scl = 1'h1;
		#(2*Q) sda_rel = 1'h0;
		#(2*Q);
	endtask
	task automatic stop();
		scl = 1'h0;
		#Q sda_rel = 1'h0;
		#Q scl = 1'h1;
		#(2*Q) sda_rel = 1'h1;
		#(2*Q);
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(b[i], r);
		end
		bit_cyc(1'h1, r);
		ack = ~r;
	endtask
	task automatic rd(input logic mack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'h1, b[i]);
		end
		bit_cyc(~mack, r);
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
module testbench;
	import iee_pkg::*;
	localparam int unsigned PROG = 2000;
	localparam logic [3:0] TYPE = 4'h5; // Arbitrary type code
	logic core_clk = 1'h0;
	logic link_clk = 1'h0;
	logic nrst = 1'h0;
	logic wp = 1'h0;
	logic scl, sda_rel, sda_o, sda_oe_n, write_busy, a;
	logic [7:0] d;
	iee_sel_t sel = 3'h5;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	// Open drain: low wins, pull-up otherwise
	wire sda = sda_rel & (sda_oe_n | sda_o);
	always #5 core_clk = ~core_clk;
	initial begin
		#3.1;
		forever #7.5 link_clk = ~link_clk;
	end
	iee_slave #(.PROG_CYCLES(PROG), .DEV_TYPE(TYPE)) iee_slave_inst (.core_clk(core_clk), .nrst(nrst),
		.core_en(1'h1), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.chip_select_pins(sel), .write_protect_input(wp), .write_busy(write_busy));
	iee_bus_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic adr(input logic [12:0] ad);
		m.start();
		m.wr({TYPE, sel, 1'h0}, a);
		chk(a, 1'h1);
		m.wr({3'h0, ad[12:8]}, a);
		chk(a, 1'h1);
		m.wr(ad[7:0], a);
		chk(a, 1'h1);
	endtask
	task automatic rd_at(input logic [12:0] ad, input int n, input logic [15:0] e);
		adr(ad);
		m.start();
		m.wr({TYPE, sel, 1'h1}, a);
		chk(a, 1'h1);
		for (int i = 0; i < n; i++) begin
			m.rd(i < n - 1, d);
			chk(d, e[15-8*i -: 8]);
		end
		m.stop();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_idle();
		chk(sda_oe_n, 1'h1);
		chk(write_busy, 1'h0);
		m.wr({TYPE, sel, 1'h0}, a);
		chk(a, 1'h0);
		m.stop();
	endtask
	task automatic t_select();
		for (int i = 0; i < 9; i++) begin
			m.start();
			m.wr({(i == 8) ? 4'h6 : TYPE, (i == 8) ? sel : 3'(i), 1'h0}, a);
			chk(a, (i == 5));
			m.stop();
		end
	endtask
	task automatic t_page();
		int n;
		adr(13'h001E);
		foreach (d[i]) begin end
		m.wr(8'hA1, a);
		chk(a, 1'h1);
		m.wr(8'hA2, a);
		chk(a, 1'h1);
		m.wr(8'hA3, a);
		chk(a, 1'h1);
		m.stop();
		chk(write_busy, 1'h1);
		n = 0;
		a = 1'h0;
		// Poll as a real master would, with a bound
		while (!a && n < 20) begin
			m.start();
			m.wr({TYPE, sel, 1'h0}, a);
			m.stop();
			n++;
		end
		chk(a, 1'h1);
		chk(n > 1, 1'h1);
		rd_at(13'h1FFF, 2, 16'hFFA3);
		rd_at(13'h001E, 1, 16'hA100);
		m.start();
		m.wr({TYPE, sel, 1'h1}, a);
		m.rd(1'h0, d);
		m.stop();
		chk(d, 8'hA2);
	endtask
	task automatic t_guard();
		@(negedge core_clk) wp = 1'h1;
		adr(13'h0040);
		m.wr(8'h5A, a);
		chk(a, 1'h0);
		m.stop();
		chk(write_busy, 1'h0);
		@(negedge core_clk) wp = 1'h0;
		adr(13'h0060);
		for (int i = 0; i < 4; i++) begin
			m.bit_cyc(1'h0, a);
		end
		m.stop();
		chk(write_busy, 1'h0);
		rd_at(13'h0040, 1, 16'hFF00);
		rd_at(13'h0060, 1, 16'hFF00);
	endtask
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			$display("[ERR] %0t run did not finish", $time);
			summarize();
		end
	end
	initial begin
		repeat (10) @(negedge core_clk);
		nrst = 1'h1;
		repeat (5) @(negedge core_clk);
		t_idle();
		t_select();
		t_page();
		t_guard();
		summarize();
	end
endmodule
